// file: oams_pkg.sv
// Constants, codes and register map shared by the slice and its controller.
// Assumes a single 250 MHz clock and 32-bit software data.
package oams_pkg;

  // ----------------------------------------------------------------
  // Datapath widths
  // ----------------------------------------------------------------
  localparam int FACTOR_W = 18;
  localparam int PRODUCT_W = 36;
  localparam int RESULT_W = 48;
  localparam int SELECTOR_W = 7;
  localparam int SHIFT_DIST = 17;
  localparam int STAGES_NONE = 0;
  localparam int STAGES_ONE = 1;
  localparam int STAGES_TWO = 2;

  // ----------------------------------------------------------------
  // Operation selector fields and codes
  // ----------------------------------------------------------------
  localparam int Z_LSB = 4;
  localparam int Y_LSB = 2;
  localparam int X_LSB = 0;
  localparam logic [2:0] Z_ZERO = 3'h0;
  localparam logic [2:0] Z_CASCADE = 3'h1;
  localparam logic [2:0] Z_RESULT = 3'h2;
  localparam logic [2:0] Z_ADDEND = 3'h3;
  localparam logic [2:0] Z_SHIFTED_CASCADE = 3'h5;
  localparam logic [2:0] Z_SHIFTED_RESULT = 3'h6;
  localparam logic [1:0] XY_ZERO = 2'h0;
  localparam logic [1:0] XY_PRODUCT = 2'h1;
  localparam logic [1:0] X_RESULT = 2'h2;
  localparam logic [1:0] X_CONCAT = 2'h3;
  localparam logic [1:0] Y_ADDEND = 2'h3;
  localparam logic [6:0] SEL_COUNT = 7'h20;
  localparam logic [6:0] SEL_PRELOAD = 7'h30;
  localparam logic [6:0] SEL_ROT_HEAD = 7'h05;
  localparam logic [6:0] SEL_ROT_TAIL = 7'h55;
  localparam logic [17:0] ROT_FACTOR = 18'h00004;

  // ----------------------------------------------------------------
  // Controller register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_SELECT = 8'h04;
  localparam logic [7:0] REG_FACTOR_A = 8'h08;
  localparam logic [7:0] REG_FACTOR_B = 8'h0c;
  localparam logic [7:0] REG_ADDEND_LO = 8'h10;
  localparam logic [7:0] REG_ADDEND_HI = 8'h14;
  localparam logic [7:0] REG_RESULT_LO = 8'h18;
  localparam logic [7:0] REG_RESULT_HI = 8'h1c;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_MODE_W = 3;
  localparam int CTL_RUN = 3;
  localparam int CTL_CLEAR = 4;
  localparam int SEL_SUBTRACT = 7;
  localparam int SEL_CARRY = 8;
  localparam int ADDEND_HI_W = 16;

  typedef enum logic [2:0]
  {
    OAMS_MODE_DIRECT = 3'h0,
    OAMS_MODE_COUNT = 3'h1,
    OAMS_MODE_PRELOAD = 3'h2,
    OAMS_MODE_ROT_HEAD = 3'h3,
    OAMS_MODE_ROT_TAIL = 3'h4
  } oams_mode_t;

  typedef enum logic [2:0]
  {
    OAMS_IDLE = 3'h1,
    OAMS_LOAD = 3'h2,
    OAMS_RUN = 3'h4
  } oams_state_t;

endpackage : oams_pkg

// file: oams_if.sv
// Connection between one arithmetic slice and its controlling logic.
// Assumes both ends share CLK; no clocking here.
interface oams_if;
  import oams_pkg::*;
  logic [FACTOR_W-1:0] factor_a;
  logic [FACTOR_W-1:0] factor_b;
  logic [RESULT_W-1:0] addend;
  logic carry_in;
  logic subtract;
  logic [SELECTOR_W-1:0] operation_selector;
  logic ce_a;
  logic rst_a;
  logic ce_p;
  logic rst_p;
  logic [RESULT_W-1:0] result;

  modport slice_end
  (
    input factor_a, factor_b, addend, carry_in, subtract, operation_selector,
    input ce_a, rst_a, ce_p, rst_p,
    output result
  );

  modport ctrl_end
  (
    output factor_a, factor_b, addend, carry_in, subtract, operation_selector,
    output ce_a, rst_a, ce_p, rst_p,
    input result
  );
endinterface : oams_if

// file: oams_slice.sv
// Arithmetic slice: 18x18 multiplier, X/Y/Z multiplexers, 48-bit add/subtract.
// Assumes the controller keeps the product pair legal and neighbours share CLK.
// Assumes operands and controls arrive unregistered, except the factor_a stages.
// Assumes a result stage for any feedback source; without it they read zero.
//
// Function
// RULE1 - Result is Z plus/minus (X+Y+carry)
// RULE2 - Subtract 0 adds, 1 subtracts
// RULE3 - Selector bits 6:4 pick Z source
// RULE4 - Selector bits 3:2 pick Y; 10 illegal
// RULE5 - Selector bits 1:0 pick X source
// RULE6 - Product selected on both X,Y or neither
// RULE7 - Shifted sources shift right seventeen bits
// RULE8 - Concat plus addend accumulates onto result
// RULE9 - Signed 18x18 product added or subtracted
// RULE10 - Cascade input summed for chained trees
// RULE11 - Three, four and six input multiplexers
// RULE12 - Pure mux: two multiplexers at zero
// RULE13 - Selector 0100000 with carry counts up
// RULE14 - Subtract high makes counter count down
// RULE15 - Preload addend plus one, then count
// RULE16 - Two-tile rotate left by two
// RULE17 - Result stage present or absent
// RULE18 - First factor zero, one, two stages
// RULE19 - Result register: enable load, sync clear
// RULE20 - Cascade output carries current result
module oams_slice
#(
  parameter int first_factor_stage_count = 1,
  parameter int result_stage_count = 1
)
(
  input wire logic CLK,
  input wire logic RESET_N,
  oams_if.slice_end LINK,
  input wire logic [oams_pkg::RESULT_W-1:0] CASCADE_INPUT,
  output logic [oams_pkg::RESULT_W-1:0] CASCADE_OUTPUT
);
  import oams_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Arithmetic shift keeps the sign of a cascaded partial sum
  function automatic logic [RESULT_W-1:0] shift_down(input logic [RESULT_W-1:0] v);
    logic signed [RESULT_W-1:0] s;
    s = $signed(v);
    shift_down = RESULT_W'(s >>> SHIFT_DIST);
  endfunction : shift_down

  function automatic logic [RESULT_W-1:0] widen_product(input logic [PRODUCT_W-1:0] p);
    widen_product = {{(RESULT_W-PRODUCT_W){p[PRODUCT_W-1]}}, p};
  endfunction : widen_product

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [FACTOR_W-1:0] a_stage [STAGES_TWO];
  logic [FACTOR_W-1:0] factor_a_eff;
  logic signed [PRODUCT_W-1:0] product;
  logic [RESULT_W-1:0] product_w;
  logic [RESULT_W-1:0] concat_w;
  logic [RESULT_W-1:0] feedback;
  logic [RESULT_W-1:0] x_mux;
  logic [RESULT_W-1:0] y_mux;
  logic [RESULT_W-1:0] z_mux;
  logic [RESULT_W-1:0] sum_term;
  logic [RESULT_W-1:0] next_result;
  logic [RESULT_W-1:0] result_q;
  logic [RESULT_W-1:0] result;
  logic [2:0] z_sel;
  logic [1:0] y_sel;
  logic [1:0] x_sel;

  // ----------------------------------------------------------------
  // Selector fields
  // ----------------------------------------------------------------
  // Selector is not registered here: a change acts at the next edge
  assign z_sel = LINK.operation_selector[Z_LSB +: 3];
  assign y_sel = LINK.operation_selector[Y_LSB +: 2];
  assign x_sel = LINK.operation_selector[X_LSB +: 2];

  // ----------------------------------------------------------------
  // First factor pipeline
  // ----------------------------------------------------------------
  // Clear needs the enable: a stopped pipe keeps its data
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      a_stage[0] <= '0;
      a_stage[1] <= '0;
    end
    else if (LINK.ce_a)
    begin
      if (LINK.rst_a)
      begin
        a_stage[0] <= '0;
        a_stage[1] <= '0;
      end
      else
      begin
        a_stage[0] <= LINK.factor_a;
        a_stage[1] <= a_stage[0];
      end
    end
  end

  // Unused stages simply drop out of the path
  always_comb
  begin
    if (first_factor_stage_count == STAGES_NONE)
      factor_a_eff = LINK.factor_a; // see RULE18
    else if (first_factor_stage_count == STAGES_ONE)
      factor_a_eff = a_stage[0]; // see RULE18
    else
      factor_a_eff = a_stage[1]; // see RULE18
  end

  // ----------------------------------------------------------------
  // Multiplier and operand forms
  // ----------------------------------------------------------------
  assign product = $signed(factor_a_eff) * $signed(LINK.factor_b); // see RULE9
  assign product_w = widen_product(product); // see RULE9
  assign concat_w = RESULT_W'({factor_a_eff, LINK.factor_b}); // see RULE8

  // Without a result stage the feedback reads zero: avoids a loop
  assign feedback = (result_stage_count == STAGES_ONE) ? result_q : '0;

  // ----------------------------------------------------------------
  // Multiplexers
  // ----------------------------------------------------------------
  // X: four inputs
  always_comb
  begin
    unique case (x_sel) // see RULE5 see RULE11
      XY_ZERO: x_mux = '0;
      XY_PRODUCT: x_mux = '0; // see RULE6
      X_RESULT: x_mux = feedback;
      X_CONCAT: x_mux = concat_w; // see RULE8
    endcase
  end

  // Y: three inputs; the product goes in whole on Y, X adds nothing
  always_comb
  begin
    unique case (y_sel) // see RULE4 see RULE11
      XY_ZERO: y_mux = '0;
      XY_PRODUCT: y_mux = product_w; // see RULE6 see RULE9
      Y_ADDEND: y_mux = LINK.addend; // see RULE8
      default: y_mux = '0;
    endcase
  end

  // Z: six inputs; codes 100 and 111 are illegal and give zero
  always_comb
  begin
    unique case (z_sel) // see RULE3 see RULE11
      Z_ZERO: z_mux = '0;
      Z_CASCADE: z_mux = CASCADE_INPUT; // see RULE10
      Z_RESULT: z_mux = feedback; // see RULE8 see RULE13
      Z_ADDEND: z_mux = LINK.addend; // see RULE15
      Z_SHIFTED_CASCADE: z_mux = shift_down(CASCADE_INPUT); // see RULE7 see RULE16
      Z_SHIFTED_RESULT: z_mux = shift_down(feedback); // see RULE7
      default: z_mux = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Adder / subtracter
  // ----------------------------------------------------------------
  // Wraps modulo two to the 48; no overflow flag is kept
  assign sum_term = x_mux + y_mux + RESULT_W'(LINK.carry_in); // see RULE1

  always_comb
  begin
    if (LINK.subtract)
      next_result = z_mux - sum_term; // see RULE2 see RULE14
    else
      next_result = z_mux + sum_term; // see RULE2 see RULE13
  end

  // ----------------------------------------------------------------
  // Result stage
  // ----------------------------------------------------------------
  // Enable gates the clear too, as on the factor stages
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      result_q <= '0;
    else if (LINK.ce_p)
    begin
      if (LINK.rst_p)
        result_q <= '0; // see RULE19
      else
        result_q <= next_result; // see RULE19
    end
  end

  // Absent stage trades feedback for one cycle less latency
  assign result = (result_stage_count == STAGES_ONE) ? result_q : next_result; // see RULE17

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Both copies are one net, so a neighbour sees no extra delay
  assign LINK.result = result;
  assign CASCADE_OUTPUT = result; // see RULE20

endmodule : oams_slice

// file: oams_ctrl.sv
// Controlling logic for one slice: software registers, modes, preload sequence.
// Assumes a plain register port and a slice on the same CLK.
//
// Added by the designer: the strobed register port and the placing of the registers.
module oams_ctrl
(
  input wire logic CLK,
  input wire logic RESET_N,
  oams_if.ctrl_end LINK,
  input wire logic [oams_pkg::ADDR_W-1:0] ADDR,
  input wire logic [oams_pkg::DATA_W-1:0] WDATA,
  input wire logic WRITE,
  input wire logic READ,
  output logic [oams_pkg::DATA_W-1:0] RDATA
);
  import oams_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  oams_mode_t mode;
  logic run;
  logic clear;
  logic [8:0] select;
  logic [FACTOR_W-1:0] factor_a;
  logic [FACTOR_W-1:0] factor_b;
  logic [RESULT_W-1:0] addend;
  oams_state_t state;
  oams_state_t next_state;
  logic [SELECTOR_W-1:0] legal_sel;
  logic ctl_write;

  assign ctl_write = WRITE && (ADDR == REG_CONTROL);

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      mode <= OAMS_MODE_DIRECT;
      run <= 1'b0;
    end
    else if (ctl_write)
    begin
      mode <= oams_mode_t'(WDATA[CTL_MODE_LSB +: CTL_MODE_W]);
      run <= WDATA[CTL_RUN];
    end
  end

  // Clear is a one-cycle pulse on the write
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      clear <= 1'b0;
    else
      clear <= ctl_write && WDATA[CTL_CLEAR];
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      select <= '0;
      factor_a <= '0;
      factor_b <= '0;
      addend <= '0;
    end
    else if (WRITE)
    begin
      if (ADDR == REG_SELECT)
        select <= WDATA[8:0];
      if (ADDR == REG_FACTOR_A)
        factor_a <= WDATA[FACTOR_W-1:0];
      if (ADDR == REG_FACTOR_B)
        factor_b <= WDATA[FACTOR_W-1:0];
      if (ADDR == REG_ADDEND_LO)
        addend[DATA_W-1:0] <= WDATA;
      if (ADDR == REG_ADDEND_HI)
        addend[RESULT_W-1:DATA_W] <= WDATA[ADDEND_HI_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Sequence: preload takes one cycle, then counting
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    unique case (state)
      OAMS_IDLE:
        if (run)
          next_state = (mode == OAMS_MODE_PRELOAD) ? OAMS_LOAD : OAMS_RUN;
      OAMS_LOAD:
        next_state = run ? OAMS_RUN : OAMS_IDLE; // see RULE15
      OAMS_RUN:
        if (!run)
          next_state = OAMS_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      state <= OAMS_IDLE;
    else
      state <= next_state;
  end

  // Half a product pair is never passed on: both fields or neither
  always_comb
  begin
    legal_sel = select[SELECTOR_W-1:0];
    if (legal_sel[X_LSB +: 2] == XY_PRODUCT || legal_sel[Y_LSB +: 2] == XY_PRODUCT)
    begin
      legal_sel[X_LSB +: 2] = XY_PRODUCT; // see RULE6
      legal_sel[Y_LSB +: 2] = XY_PRODUCT; // see RULE6
    end
  end

  // ----------------------------------------------------------------
  // Drive the slice
  // ----------------------------------------------------------------
  always_comb
  begin
    LINK.factor_a = factor_a;
    LINK.factor_b = factor_b;
    LINK.addend = addend;
    LINK.subtract = select[SEL_SUBTRACT]; // see RULE14
    LINK.carry_in = select[SEL_CARRY];
    LINK.operation_selector = legal_sel;
    unique case (mode)
      OAMS_MODE_COUNT:
      begin
        LINK.carry_in = 1'b1; // see RULE13
        LINK.operation_selector = SEL_COUNT; // see RULE13
      end
      OAMS_MODE_PRELOAD:
      begin
        LINK.carry_in = 1'b1; // see RULE15
        LINK.operation_selector = (state == OAMS_RUN) ? SEL_COUNT : SEL_PRELOAD; // see RULE15
      end
      OAMS_MODE_ROT_HEAD:
      begin
        LINK.factor_a = {1'b0, factor_a[FACTOR_W-1:1]}; // see RULE16
        LINK.factor_b = ROT_FACTOR; // see RULE16
        LINK.subtract = 1'b0;
        LINK.carry_in = 1'b0;
        LINK.operation_selector = SEL_ROT_HEAD;
      end
      OAMS_MODE_ROT_TAIL:
      begin
        LINK.factor_b = ROT_FACTOR; // see RULE16
        LINK.subtract = 1'b0;
        LINK.carry_in = 1'b0;
        LINK.operation_selector = SEL_ROT_TAIL; // see RULE16
      end
      default:
      begin
      end
    endcase
  end

  assign LINK.ce_a = run;
  assign LINK.ce_p = (state != OAMS_IDLE) || clear;
  assign LINK.rst_a = clear;
  assign LINK.rst_p = clear; // see RULE19

  // ----------------------------------------------------------------
  // Read port: data one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      RDATA <= '0;
    else if (READ)
    begin
      unique case (ADDR)
        REG_CONTROL: RDATA <= DATA_W'({run, mode});
        REG_SELECT: RDATA <= DATA_W'(select);
        REG_FACTOR_A: RDATA <= DATA_W'(factor_a);
        REG_FACTOR_B: RDATA <= DATA_W'(factor_b);
        REG_ADDEND_LO: RDATA <= addend[DATA_W-1:0];
        REG_ADDEND_HI: RDATA <= DATA_W'(addend[RESULT_W-1:DATA_W]);
        REG_RESULT_LO: RDATA <= LINK.result[DATA_W-1:0];
        REG_RESULT_HI: RDATA <= DATA_W'(LINK.result[RESULT_W-1:DATA_W]);
        REG_STATUS: RDATA <= DATA_W'(state);
        default: RDATA <= '0;
      endcase
    end
    else
      RDATA <= '0;
  end

endmodule : oams_ctrl

// file: oams_monitor.sv
// Assertions on the link between one controller and one slice.
// Assumes one clock; feedback checks need the result stage present.
module oams_monitor
#(
  parameter int result_stage_count = 1
)
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [oams_pkg::SELECTOR_W-1:0] operation_selector,
  input wire logic carry_in,
  input wire logic subtract,
  input wire logic [oams_pkg::RESULT_W-1:0] addend,
  input wire logic ce_p,
  input wire logic rst_p,
  input wire logic [oams_pkg::RESULT_W-1:0] result
);
  import oams_pkg::*;
  logic staged;
  logic live;
  // Without the stage the result is combinational, so no edge relations
  assign staged = (result_stage_count == STAGES_ONE);
  assign live = staged && ce_p && !rst_p;

  function automatic logic [47:0] sra17(input logic [47:0] v);
    return {{17{v[47]}}, v[47:17]};
  endfunction : sra17

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_hold_disabled: assert property (staged && !ce_p |=> $stable(result))
    else $error("result changed with enable low");
  a_clear_result: assert property (staged && ce_p && rst_p |=> result == '0)
    else $error("result not cleared");
  a_count_twice: assert property ((live && operation_selector == SEL_COUNT
    && carry_in && !subtract) [*2] |=> result == $past(result, 2) + 48'h2)
    else $error("up count missed a step");
  a_count_down: assert property (live && operation_selector == SEL_COUNT
    && subtract |=> result == $past(result) - $past(carry_in))
    else $error("down count wrong");
  a_preload_load: assert property (live && operation_selector == SEL_PRELOAD
    && !subtract |=> result == $past(addend) + $past(carry_in))
    else $error("preload not addend plus carry");
  a_y_illegal: assert property (live && operation_selector == 7'h08 && !subtract
    |=> result == {47'h0, $past(carry_in)})
    else $error("illegal Y code not zero");
  a_shift_back: assert property (live && operation_selector == 7'h60 && !subtract
    |=> result == sra17($past(result)) + $past(carry_in))
    else $error("shifted result wrong");
  a_pair_product: assert property ((operation_selector[1:0] == XY_PRODUCT)
    == (operation_selector[3:2] == XY_PRODUCT))
    else $error("product on one multiplexer only");

  c_count: cover property (live && operation_selector == SEL_COUNT);
  c_preload: cover property (live && operation_selector == SEL_PRELOAD);
  c_clear: cover property (ce_p && rst_p);
endmodule : oams_monitor

// file: tb_operation_selector_add_mult_slice.sv
// Bench: controller and slice joined by the link, checked against a model.
// Assumes the plain register port and a cascade input driven here.
module tb_operation_selector_add_mult_slice;
  timeunit 1ns;
  timeprecision 1ps;
  import oams_pkg::*;
  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic [7:0] ADDR = 8'h0;
  logic [31:0] WDATA = 32'h0;
  logic WRITE = 1'b0;
  logic READ = 1'b0;
  logic [31:0] RDATA;
  logic [47:0] casc = 48'h0;
  logic [47:0] cout;
  int n_mismatch = 0;
  int cmp_count = 0;

  oams_if link();
  oams_ctrl u_oams_ctrl (.CLK(CLK), .RESET_N(RESET_N), .LINK(link), .ADDR(ADDR),
    .WDATA(WDATA), .WRITE(WRITE), .READ(READ), .RDATA(RDATA));
  oams_slice #(.first_factor_stage_count(1), .result_stage_count(1)) u_oams_slice
    (.CLK(CLK), .RESET_N(RESET_N), .LINK(link), .CASCADE_INPUT(casc), .CASCADE_OUTPUT(cout));
  oams_monitor #(.result_stage_count(1)) u_oams_monitor (.CLK(CLK), .RESET_N(RESET_N),
    .operation_selector(link.operation_selector), .carry_in(link.carry_in),
    .subtract(link.subtract), .addend(link.addend), .ce_p(link.ce_p), .rst_p(link.rst_p),
    .result(link.result));

  initial
  begin
    forever #2 CLK = ~CLK;
  end

  // ----------------------------------------------------------------
  // Port tasks and model
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WRITE <= 1'b1;
    @(posedge CLK);
    WRITE <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge CLK);
    ADDR <= a;
    READ <= 1'b1;
    @(posedge CLK);
    READ <= 1'b0;
    @(negedge CLK);
    v = RDATA;
  endtask : rd

  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic getres(output logic [47:0] r);
    logic [31:0] lo;
    logic [31:0] hi;
    rd(REG_RESULT_LO, lo);
    rd(REG_RESULT_HI, hi);
    r = {hi[15:0], lo};
  endtask : getres

  // Live result read twice, two cycles apart, then stop
  task automatic fb(input logic [31:0] sw, input logic [31:0] cw, input logic [31:0] st,
    output logic [31:0] v1);
    logic [31:0] v2;
    wr(REG_SELECT, sw);
    wr(REG_CONTROL, cw);
    repeat (4) @(posedge CLK);
    rd(REG_RESULT_LO, v1);
    rd(REG_RESULT_LO, v2);
    wr(REG_CONTROL, 32'h0);
    chk("step", {16'h0, st}, {16'h0, v2 - v1});
  endtask : fb

  function automatic logic [47:0] model(input logic [6:0] s, input logic sub, input logic ci,
    input logic [17:0] a, input logic [17:0] b, input logic [47:0] c, input logic [47:0] k);
    longint x;
    longint y;
    longint z;
    logic prod;
    prod = (s[1:0] == 2'h1) || (s[3:2] == 2'h1);
    x = (!prod && s[1:0] == 2'h3) ? longint'({a, b}) : 0;
    y = prod ? longint'($signed(a)) * longint'($signed(b)) : (s[3:2] == 2'h3 ? longint'(c) : 0);
    z = s[6:4] == 3'h1 ? longint'(k) : s[6:4] == 3'h3 ? longint'(c) : 0;
    if (s[6:4] == 3'h5)
      z = longint'($signed(k)) >>> 17;
    return 48'(sub ? z - (x + y + ci) : z + x + y + ci);
  endfunction : model

  task give_verdict;
    $display("TB: compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  initial
  begin
    #40000;
    n_mismatch++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    static logic [6:0] sels [11] = '{7'h08, 7'h05, 7'h01, 7'h03, 7'h0c, 7'h30, 7'h10, 7'h50,
      7'h3f, 7'h15, 7'h40};
    logic [17:0] a;
    logic [17:0] b;
    logic [47:0] c;
    logic [47:0] res;
    logic [47:0] expv;
    logic [31:0] d;
    logic ci;
    logic sub;
    void'($urandom(32'ha6c32df3));
    repeat (3) @(posedge CLK);
    RESET_N <= 1'b1;
    rd(REG_STATUS, d);
    chk("status", 48'h1, {16'h0, d});
    wr(8'h24, 32'hffffffff);
    rd(8'h24, d);
    chk("unmapped", 48'h0, {16'h0, d});
    getres(res);
    chk("reset result", 48'h0, res);
    for (int i = 0; i < 11; i++)
    begin
      a = 18'($urandom);
      b = 18'($urandom);
      c = {16'($urandom), 32'($urandom)};
      ci = 1'($urandom);
      sub = i[0];
      @(posedge CLK);
      casc <= {16'($urandom), 32'($urandom)};
      wr(REG_SELECT, {23'h0, ci, sub, sels[i]});
      wr(REG_FACTOR_A, {14'h0, a});
      wr(REG_FACTOR_B, {14'h0, b});
      wr(REG_ADDEND_LO, c[31:0]);
      wr(REG_ADDEND_HI, {16'h0, c[47:32]});
      wr(REG_CONTROL, 32'h8);
      repeat (4) @(posedge CLK);
      wr(REG_CONTROL, 32'h0);
      getres(res);
      expv = model(sels[i], sub, ci, a, b, c, casc);
      chk("direct", expv, res);
      chk("cascade", expv, cout);
    end
    fb({23'h0, ci, 8'h2f}, 32'h8, 32'(2 * ({a, b} + c + ci)), d);
    fb(32'h60, 32'h8, 32'h0, d);
    wr(REG_CONTROL, 32'h10);
    getres(res);
    chk("clear", 48'h0, res);
    fb(32'h120, 32'h9, 32'h2, d);
    chk("count start", 48'h4, {16'h0, d});
    fb(32'h1a0, 32'h9, 32'hfffffffe, d);
    fb(32'h102, 32'h8, 32'h2, d);
    fb(32'h100, 32'ha, 32'h2, d);
    chk("preload", {16'h0, c[31:0] + 32'h4}, {16'h0, d});
    a = 18'($urandom);
    wr(REG_FACTOR_A, {14'h0, a});
    wr(REG_CONTROL, 32'hb);
    repeat (4) @(posedge CLK);
    wr(REG_CONTROL, 32'h3);
    getres(res);
    chk("rotate head", {29'h0, a[17:1], 2'h0}, res);
    @(posedge CLK);
    casc <= res;
    wr(REG_CONTROL, 32'hc);
    repeat (4) @(posedge CLK);
    wr(REG_CONTROL, 32'h4);
    getres(res);
    chk("rotate", {30'h0, a[15:0], a[17:16]}, {30'h0, res[17:0]});
    wr(REG_CONTROL, 32'h9);
    @(posedge CLK);
    RESET_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RESET_N <= 1'b1;
    getres(res);
    chk("mid reset", 48'h0, res);
    give_verdict();
  end
endmodule : tb_operation_selector_add_mult_slice
